// >>> inc/ptmc_pkg.sv
package ptmc_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] PTMC_IDX_MODE = 8'h2A;
  localparam logic [7:0] PTMC_IDX_PRESCALE_LOWER = 8'h2B;
  localparam logic [7:0] PTMC_IDX_RELOAD_HI = 8'h2C;
  localparam logic [7:0] PTMC_IDX_RELOAD_LO = 8'h2D;
  localparam logic [7:0] PTMC_IDX_COUNTER_HI = 8'h2E;
  localparam logic [7:0] PTMC_IDX_COUNTER_LO = 8'h2F;
  localparam logic [7:0] PTMC_IDX_CONTROL = 8'h20;
  localparam logic [7:0] PTMC_IDX_STATUS = 8'h21;
  localparam logic [7:0] PTMC_IDX_IRQ_MASK = 8'h22;
  localparam int PTMC_ADDR_LSB = 2;
  localparam int PTMC_ADDR_W = 12;

  // ==========================================================
  // mode register fields
  localparam int PTMC_MODE_AUTO_START = 7;
  localparam int PTMC_MODE_GATE_HI = 6;
  localparam int PTMC_MODE_GATE_LO = 5;
  localparam int PTMC_MODE_AUTO_RELOAD = 4;
  localparam int PTMC_MODE_PRE_HI = 3;
  localparam logic [7:0] PTMC_MODE_RESET = 8'h00;

  // control register fields
  localparam int PTMC_CTL_STOP_NOW = 0;
  localparam int PTMC_CTL_START_NOW = 1;
  localparam int PTMC_CTL_EVEN_PRESCALE = 2;
  localparam int PTMC_CTL_MULTI_FRAME = 3;
  localparam int PTMC_CTL_INITIAL_FIELD_ON = 4;
  localparam logic [7:0] PTMC_CTL_RESET = 8'h00;
  localparam logic [7:0] PTMC_CTL_STORED = 8'h1C;

  // status / mask fields
  localparam int PTMC_ST_EXPIRY = 0;
  localparam int PTMC_ST_STARTED = 1;
  localparam int PTMC_ST_STOPPED = 2;
  localparam int PTMC_ST_RUNNING = 7;
  localparam int PTMC_EVT_W = 3;
  localparam logic [7:0] PTMC_BYTE_RESET = 8'h00;

  // ==========================================================
  // gate select encodings
  typedef enum logic [1:0] {
    PTMC_GATE_NONE = 2'b00,
    PTMC_GATE_SECURE = 2'b01,
    PTMC_GATE_AUX_PIN_ONE = 2'b10,
    PTMC_GATE_ADDR3 = 2'b11
  } ptmc_gate_e;

  // received-bit counts after which protocol stop fires
  localparam logic [2:0] PTMC_STOP_BITS_106 = 3'h5;
  localparam logic [2:0] PTMC_STOP_BITS_OTHER = 3'h4;

  localparam logic [1:0] PTMC_RESP_OKAY = 2'b00;
  localparam logic [1:0] PTMC_RESP_SLVERR = 2'b10;
endpackage : ptmc_pkg

// >>> rtl/ptmc_prescaler.sv
module ptmc_prescaler
  import ptmc_pkg::*;
#(
  parameter int PW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic even_prescale_select,
  input wire logic [PW-1:0] prescale,
  output logic tick
);
  // ==========================================================
  // divisor arithmetic
  function automatic logic [PW+1:0] ptmc_div_last(input logic [PW-1:0] p, input logic even);
    logic [PW+1:0] d;
    d = {1'b0, p, 1'b0} + {{(PW+1){1'b0}}, even};
    return d;
  endfunction : ptmc_div_last

  logic [PW+1:0] cnt_q;
  logic [PW+1:0] last;

  // divide by 2p+1 (count 0..2p) or 2p+2 (count 0..2p+1)
  assign last = ptmc_div_last(prescale, even_prescale_select);

  // phase restarts whenever the timer is idle or gated closed
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : ptmc_prescaler

// >>> rtl/ptmc_timer.sv
// Functional notes
// - auto-start: start at every transmit end, and on field on if initial-field-on set
// - auto-start, single frame: 106 kbit A/B modes stop after fifth received bit
// - auto-start, single frame: other modes stop after fourth received bit
// - multi-frame receive: no bit-based stop; stop-now write or expiry with auto-reload clear stops timer
// - auto-start off: protocol events neither start nor stop the timer
// - gate select: 00 none, 01 secure input, 10 aux pin one, 11 address pin three
// - running flag shows register enable, ignoring gate level; flag never affects gate
// - auto-reload set: at zero reload and keep counting down
// - auto-reload clear: count to zero, stop, set expiry flag
// - prescale is lower four mode bits joined above lower prescale byte
// - even select clear: tick every 2*prescale+1 clocks
// - even select set: tick every 2*prescale+2 clocks
// - even select resets to zero
// - each start loads 16-bit reload; reload writes apply at next start or auto-reload
// - lower prescale byte is separate read-write register, reset to zero
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module ptmc_timer
  import ptmc_pkg::*;
#(
  parameter int CW = 16,
  parameter int PW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [PTMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PTMC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protocol events
  input wire logic tx_end_pulse,
  input wire logic field_on_pulse,
  input wire logic rx_bit_pulse,
  input wire logic mode_106_ab,
  // gate sources
  input wire logic secure_signal_in,
  input wire logic aux_pin_one,
  input wire logic address_pin_three,
  // status
  output logic running_flag,
  output logic expiry_irq_flag,
  output logic irq
);
  // ==========================================================
  // address decode
  function automatic logic ptmc_hit(input logic [PTMC_ADDR_W-1:0] a, input logic [7:0] idx);
    logic [PTMC_ADDR_W-1:0] full;
    full = {{(PTMC_ADDR_W-8-PTMC_ADDR_LSB){1'b0}}, idx, {PTMC_ADDR_LSB{1'b0}}};
    return a == full;
  endfunction : ptmc_hit

  function automatic logic ptmc_mapped(input logic [PTMC_ADDR_W-1:0] a);
    return ptmc_hit(a, PTMC_IDX_MODE) || ptmc_hit(a, PTMC_IDX_PRESCALE_LOWER)
      || ptmc_hit(a, PTMC_IDX_RELOAD_HI) || ptmc_hit(a, PTMC_IDX_RELOAD_LO)
      || ptmc_hit(a, PTMC_IDX_COUNTER_HI) || ptmc_hit(a, PTMC_IDX_COUNTER_LO)
      || ptmc_hit(a, PTMC_IDX_CONTROL) || ptmc_hit(a, PTMC_IDX_STATUS)
      || ptmc_hit(a, PTMC_IDX_IRQ_MASK);
  endfunction : ptmc_mapped

  // ==========================================================
  // registers
  logic [7:0] mode_q;
  logic [7:0] prescale_lower_q;
  logic [7:0] reload_hi_q;
  logic [7:0] reload_lo_q;
  logic [7:0] control_q;
  logic [7:0] mask_q;
  logic [PTMC_EVT_W-1:0] status_q;
  logic [PTMC_EVT_W-1:0] status_d;
  logic [CW-1:0] counter_q;
  logic running_q;
  logic [2:0] rx_bits_q;

  // write channel capture
  logic aw_held_q;
  logic w_held_q;
  logic [PTMC_ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic wr_fire;
  logic stop_now_wr;
  logic start_now_wr;
  logic status_rd;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign stop_now_wr = wr_fire && wlane_q && ptmc_hit(awaddr_q, PTMC_IDX_CONTROL)
    && wbyte_q[PTMC_CTL_STOP_NOW];
  assign start_now_wr = wr_fire && wlane_q && ptmc_hit(awaddr_q, PTMC_IDX_CONTROL)
    && wbyte_q[PTMC_CTL_START_NOW];
  assign status_rd = s_axi_arvalid && s_axi_arready && ptmc_hit(s_axi_araddr, PTMC_IDX_STATUS);

  // ==========================================================
  // axi write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q <= PTMC_BYTE_RESET;
      wlane_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PTMC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= ptmc_mapped(awaddr_q) ? PTMC_RESP_OKAY : PTMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // software registers; counter and status are read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= PTMC_MODE_RESET;
      prescale_lower_q <= PTMC_BYTE_RESET;
      reload_hi_q <= PTMC_BYTE_RESET;
      reload_lo_q <= PTMC_BYTE_RESET;
      control_q <= PTMC_CTL_RESET;
      mask_q <= PTMC_BYTE_RESET;
    end else if (wr_fire && wlane_q) begin
      if (ptmc_hit(awaddr_q, PTMC_IDX_MODE)) begin
        mode_q <= wbyte_q;
      end
      if (ptmc_hit(awaddr_q, PTMC_IDX_PRESCALE_LOWER)) begin
        prescale_lower_q <= wbyte_q;
      end
      if (ptmc_hit(awaddr_q, PTMC_IDX_RELOAD_HI)) begin
        reload_hi_q <= wbyte_q;
      end
      if (ptmc_hit(awaddr_q, PTMC_IDX_RELOAD_LO)) begin
        reload_lo_q <= wbyte_q;
      end
      // stop and start bits are strobes and never stored
      if (ptmc_hit(awaddr_q, PTMC_IDX_CONTROL)) begin
        control_q <= wbyte_q & PTMC_CTL_STORED;
      end
      if (ptmc_hit(awaddr_q, PTMC_IDX_IRQ_MASK)) begin
        mask_q <= wbyte_q;
      end
    end
  end

  // ==========================================================
  // mode decode
  logic auto_start_enable;
  logic auto_reload_enable;
  logic multi_frame_receive;
  logic initial_field_on;
  logic even_prescale_select;
  ptmc_gate_e gate_select;
  logic gate_open;
  logic [PW-1:0] prescale;
  logic [CW-1:0] reload_value;
  logic tick;

  assign auto_start_enable = mode_q[PTMC_MODE_AUTO_START];
  assign auto_reload_enable = mode_q[PTMC_MODE_AUTO_RELOAD];
  assign gate_select = ptmc_gate_e'(mode_q[PTMC_MODE_GATE_HI:PTMC_MODE_GATE_LO]);
  assign multi_frame_receive = control_q[PTMC_CTL_MULTI_FRAME];
  assign initial_field_on = control_q[PTMC_CTL_INITIAL_FIELD_ON];
  assign even_prescale_select = control_q[PTMC_CTL_EVEN_PRESCALE];
  assign prescale = {mode_q[PTMC_MODE_PRE_HI:0], prescale_lower_q};
  assign reload_value = {reload_hi_q, reload_lo_q};

  // gate level only holds the count; running flag is independent of it
  always_comb begin
    case (gate_select)
      PTMC_GATE_NONE: gate_open = 1'b1;
      PTMC_GATE_SECURE: gate_open = secure_signal_in;
      PTMC_GATE_AUX_PIN_ONE: gate_open = aux_pin_one;
      PTMC_GATE_ADDR3: gate_open = address_pin_three;
      default: gate_open = 1'b1;
    endcase
  end

  ptmc_prescaler #(
    .PW(PW)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(running_q && gate_open),
    .even_prescale_select(even_prescale_select),
    .prescale(prescale),
    .tick(tick)
  );

  // ==========================================================
  // start and stop events
  logic proto_start;
  logic proto_stop;
  logic start_evt;
  logic stop_evt;
  logic expire;
  logic [2:0] stop_bits;

  assign proto_start = auto_start_enable
    && (tx_end_pulse || (initial_field_on && field_on_pulse));
  assign stop_bits = mode_106_ab ? PTMC_STOP_BITS_106 : PTMC_STOP_BITS_OTHER;
  assign proto_stop = auto_start_enable && !multi_frame_receive && running_q
    && rx_bit_pulse && (rx_bits_q + 3'h1 == stop_bits);
  assign start_evt = proto_start || start_now_wr;
  assign stop_evt = (proto_stop || stop_now_wr) && !start_evt;
  assign expire = running_q && gate_open && tick && counter_q == '0
    && !start_evt && !stop_evt;

  // received bits counted only since the latest start
  always_ff @(posedge aclk) begin
    if (!aresetn || start_evt || !running_q) begin
      rx_bits_q <= '0;
    end else if (rx_bit_pulse && rx_bits_q != stop_bits) begin
      rx_bits_q <= rx_bits_q + 3'h1;
    end
  end

  // ==========================================================
  // count-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running_q <= 1'b0;
      counter_q <= '0;
    end else if (start_evt) begin
      running_q <= 1'b1;
      counter_q <= reload_value;
    end else if (stop_evt) begin
      running_q <= 1'b0;
    end else if (expire) begin
      if (auto_reload_enable) begin
        counter_q <= reload_value;
      end else begin
        running_q <= 1'b0;
      end
    end else if (running_q && gate_open && tick) begin
      counter_q <= counter_q - 1'b1;
    end
  end

  // ==========================================================
  // sticky status; a new event outranks the read that clears it
  logic [PTMC_EVT_W-1:0] status_set;

  assign status_set = {stop_evt && running_q, start_evt,
    expire && !auto_reload_enable};

  always_comb begin
    status_d = status_q;
    if (status_rd) begin
      status_d = '0;
    end
    status_d = status_d | status_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
      running_flag <= 1'b0;
      expiry_irq_flag <= 1'b0;
    end else begin
      status_q <= status_d;
      irq <= |(status_d & mask_q[PTMC_EVT_W-1:0]);
      running_flag <= running_d();
      expiry_irq_flag <= status_d[PTMC_ST_EXPIRY];
    end
  end

  // next running state, mirrored so the output flop matches running_q
  function automatic logic running_d();
    logic r;
    r = running_q;
    if (start_evt) begin
      r = 1'b1;
    end else if (stop_evt || (expire && !auto_reload_enable)) begin
      r = 1'b0;
    end
    return r;
  endfunction : running_d

  // ==========================================================
  // axi read path, answer one cycle after address taken
  logic [7:0] rbyte;

  always_comb begin
    rbyte = PTMC_BYTE_RESET;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_MODE)) rbyte = mode_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_PRESCALE_LOWER)) rbyte = prescale_lower_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_RELOAD_HI)) rbyte = reload_hi_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_RELOAD_LO)) rbyte = reload_lo_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_COUNTER_HI)) rbyte = counter_q[CW-1:8];
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_COUNTER_LO)) rbyte = counter_q[7:0];
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_CONTROL)) rbyte = control_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_IRQ_MASK)) rbyte = mask_q;
    if (ptmc_hit(s_axi_araddr, PTMC_IDX_STATUS)) begin
      rbyte[PTMC_EVT_W-1:0] = status_q;
      rbyte[PTMC_ST_RUNNING] = running_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PTMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rbyte};
        s_axi_rresp <= ptmc_mapped(s_axi_araddr) ? PTMC_RESP_OKAY : PTMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : ptmc_timer

// >>> test/ptmc_timer_assertions.sv
module ptmc_timer_chk
  import ptmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PTMC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic tx_end_pulse,
  input wire logic rx_bit_pulse,
  input wire logic mode_106_ab,
  input wire logic running_flag,
  input wire logic expiry_irq_flag,
  input wire logic irq
);
  // ==========================================================
  // shadow registers, one cycle behind the design's own copy
  logic [7:0] aw_q, wd_q, mode_q, ctl_q, mask_q;
  logic bv_q;
  logic [2:0] bits_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      mode_q <= 8'h00;
      ctl_q <= 8'h00;
      mask_q <= 8'h00;
      bv_q <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr[9:2];
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_bvalid && !bv_q && aw_q == PTMC_IDX_MODE) mode_q <= wd_q;
      if (s_axi_bvalid && !bv_q && aw_q == PTMC_IDX_CONTROL) ctl_q <= wd_q;
      if (s_axi_bvalid && !bv_q && aw_q == PTMC_IDX_IRQ_MASK) mask_q <= wd_q;
    end
  end
  // received bits while running since the last auto-start transmit end
  always_ff @(posedge aclk) begin
    if (!aresetn || (tx_end_pulse && mode_q[PTMC_MODE_AUTO_START])) bits_q <= 3'h0;
    else if (rx_bit_pulse && running_flag && bits_q != 3'h7) bits_q <= bits_q + 3'h1;
  end
  // ==========================================================
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_autostart_run: assert property (
    tx_end_pulse && mode_q[PTMC_MODE_AUTO_START] |=> running_flag)
    else $error("auto start did not run the timer");
  a_manual_quiet: assert property (
    tx_end_pulse && !mode_q[PTMC_MODE_AUTO_START] && !running_flag
    |=> !running_flag || $rose(s_axi_bvalid))
    else $error("protocol event started a manual timer");
  a_multi_keeps: assert property (
    running_flag && rx_bit_pulse && ctl_q[PTMC_CTL_MULTI_FRAME]
    |=> running_flag || $rose(s_axi_bvalid))
    else $error("multi frame timer stopped on a bit");
  a_bit_stop: assert property (
    running_flag && rx_bit_pulse && !tx_end_pulse && mode_q[PTMC_MODE_AUTO_START]
    && !ctl_q[PTMC_CTL_MULTI_FRAME] && bits_q == (mode_106_ab ? 3'h4 : 3'h3)
    |=> !running_flag)
    else $error("timer not stopped on the last counted bit");
  a_expiry_stops: assert property (
    $rose(expiry_irq_flag) && !mode_q[PTMC_MODE_AUTO_RELOAD] |-> !running_flag)
    else $error("timer kept running after expiry");
  a_reload_keeps: assert property (
    running_flag && mode_q[PTMC_MODE_AUTO_RELOAD] && !mode_q[PTMC_MODE_AUTO_START]
    |=> running_flag || $rose(s_axi_bvalid))
    else $error("auto reload timer stopped");
  a_irq_follows: assert property (
    expiry_irq_flag && mask_q[PTMC_ST_EXPIRY] |-> irq)
    else $error("unmasked expiry without interrupt");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !running_flag && !irq && !expiry_irq_flag)
    else $error("outputs active right after reset");
endmodule : ptmc_timer_chk

bind ptmc_timer ptmc_timer_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .tx_end_pulse,
  .rx_bit_pulse, .mode_106_ab, .running_flag, .expiry_irq_flag, .irq);

// >>> test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ptmc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PTMC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tx_end_pulse = 0, field_on_pulse = 0, rx_bit_pulse = 0, mode_106_ab = 0;
  logic secure_signal_in = 0, aux_pin_one = 0, address_pin_three = 0;
  logic running_flag, expiry_irq_flag, irq;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] v, w;
  logic [11:0] p;
  int n1, n3;

  ptmc_timer u_ptmc_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_end_pulse, .field_on_pulse, .rx_bit_pulse, .mode_106_ab,
    .secure_signal_in, .aux_pin_one, .address_pin_three, .running_flag, .expiry_irq_flag, .irq);

  initial forever #5 aclk = ~aclk;

  // ==========================================================
  // checking and closing
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chkf(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkf
  function automatic int div(int pv, int ev);
    return 2 * pv + 1 + ev;
  endfunction : div

  // ==========================================================
  // register bus master
  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = PTMC_RESP_OKAY);
    bit a, b;
    a = 0;
    b = 0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && b)) begin
      @(posedge aclk);
      if (!a && s_axi_awready) begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!b && s_axi_wready) begin
        b = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er = PTMC_RESP_OKAY);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // one-cycle event pulse: 0 transmit end, 1 received bit, 2 field on
  task pul(input int k);
    {field_on_pulse, rx_bit_pulse, tx_end_pulse} <= 3'(1 << k);
    @(posedge aclk);
    {field_on_pulse, rx_bit_pulse, tx_end_pulse} <= 3'h0;
    @(posedge aclk);
  endtask : pul
  // offset of start and stop cancels out between two lengths
  task dur(input logic [15:0] r, input logic [7:0] c, output int n);
    wr(PTMC_IDX_RELOAD_HI, r[15:8]);
    wr(PTMC_IDX_RELOAD_LO, r[7:0]);
    wr(PTMC_IDX_CONTROL, c | 8'h02);
    n = 0;
    while (running_flag === 1'b1 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
  endtask : dur

  // ==========================================================
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h0D2760EB));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(PTMC_IDX_MODE, v);
    chk(v, 32'h0);
    rd(PTMC_IDX_PRESCALE_LOWER, v);
    chk(v, 32'h0);
    rd(PTMC_IDX_CONTROL, v);
    chk(v, 32'h0);
    rd(8'h3F, v, PTMC_RESP_SLVERR);
    chk(v, 32'h0);
    for (int i = 0; i < 4; i++) begin
      p = 12'($urandom);
      wr(PTMC_IDX_MODE, {1'b0, p[10:4]});
      wr(PTMC_IDX_PRESCALE_LOWER, p[7:0]);
      rd(PTMC_IDX_MODE, v);
      chk(v, {25'h0, p[10:4]});
      rd(PTMC_IDX_PRESCALE_LOWER, v);
      chk(v, {24'h0, p[7:0]});
    end
    wr(8'h3F, 8'hFF, PTMC_RESP_SLVERR);
    // a write without lane 0 must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(PTMC_IDX_MODE, {1'b0, ~p[10:4]});
    s_axi_wstrb <= 4'hF;
    rd(PTMC_IDX_MODE, v);
    chk(v, {25'h0, p[10:4]});
    $display("test registers done");
    wr(PTMC_IDX_IRQ_MASK, 8'h01);
    for (int e = 0; e < 2; e++) begin
      p = 12'($urandom_range(511));
      wr(PTMC_IDX_MODE, {4'h0, p[11:8]});
      wr(PTMC_IDX_PRESCALE_LOWER, p[7:0]);
      dur(16'h0003, 8'(e << 2), n3);
      chkf(expiry_irq_flag, 1'b1);
      chkf(irq, 1'b1);
      rd(PTMC_IDX_STATUS, v);
      chk(v, 32'h3);
      chkf(irq, 1'b0);
      dur(16'h0001, 8'(e << 2), n1);
      chk(n3 - n1, 2 * div(p, e));
    end
    $display("test prescale done");
    wr(PTMC_IDX_PRESCALE_LOWER, 8'h00);
    wr(PTMC_IDX_MODE, 8'h10);
    rd(PTMC_IDX_STATUS, v);
    dur(16'h0002, 8'h00, n1);
    chkf(running_flag, 1'b1);
    chkf(expiry_irq_flag, 1'b0);
    wr(PTMC_IDX_CONTROL, 8'h01);
    chkf(running_flag, 1'b0);
    $display("test reload done");
    wr(PTMC_IDX_RELOAD_HI, 8'hFF);
    wr(PTMC_IDX_RELOAD_LO, 8'hFF);
    wr(PTMC_IDX_PRESCALE_LOWER, 8'hFF);
    wr(PTMC_IDX_MODE, 8'h8F);
    for (int c = 0; c < 4; c++) begin
      mode_106_ab <= c[0];
      wr(PTMC_IDX_CONTROL, 8'(c[1] << 3));
      pul(0);
      chkf(running_flag, 1'b1);
      repeat (c[0] ? 4 : 3) pul(1);
      chkf(running_flag, 1'b1);
      pul(1);
      chkf(running_flag, c[1]);
      wr(PTMC_IDX_CONTROL, 8'(c[1] << 3) | 8'h01);
      chkf(running_flag, 1'b0);
    end
    wr(PTMC_IDX_CONTROL, 8'h10);
    pul(2);
    chkf(running_flag, 1'b1);
    wr(PTMC_IDX_CONTROL, 8'h01);
    wr(PTMC_IDX_MODE, 8'h0F);
    pul(0);
    chkf(running_flag, 1'b0);
    $display("test protocol done");
    wr(PTMC_IDX_PRESCALE_LOWER, 8'h00);
    for (int g = 1; g < 4; g++) begin
      wr(PTMC_IDX_MODE, 8'(g << 5));
      {address_pin_three, aux_pin_one, secure_signal_in} <= ~(3'h1 << (g - 1));
      wr(PTMC_IDX_CONTROL, 8'h02);
      rd(PTMC_IDX_COUNTER_LO, v);
      repeat (8) @(posedge aclk);
      rd(PTMC_IDX_COUNTER_LO, w);
      chk(w, v);
      chkf(running_flag, 1'b1);
      {address_pin_three, aux_pin_one, secure_signal_in} <= 3'h1 << (g - 1);
      repeat (8) @(posedge aclk);
      rd(PTMC_IDX_COUNTER_LO, v);
      chkf(v < w, 1'b1);
      wr(PTMC_IDX_CONTROL, 8'h01);
    end
    $display("test gate done");
    // reset in mid-run with the timer counting
    wr(PTMC_IDX_CONTROL, 8'h06);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chkf(running_flag, 1'b0);
    rd(PTMC_IDX_MODE, v);
    chk(v, 32'h0);
    rd(PTMC_IDX_CONTROL, v);
    chk(v, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : tb
